// *** hdl/tcc_params.svh ***
// constants of the temperature conversion command block
`ifndef TCC_PARAMS_SVH
`define TCC_PARAMS_SVH
`define TCC_ADDR_W 10
`define TCC_CMD_ADDR 10'h000
`define TCC_RES_BASE 10'h010
`define TCC_RES_END 10'h05f
`define TCC_ASSIGN_BASE 10'h200
`define TCC_ASSIGN_END 10'h24f
`define TCC_START_BIT 7
`define TCC_DONE_BIT 6
`define TCC_SPARE_BIT 5
`define TCC_CHAN_HI 4
`define TCC_CHAN_W 5
`define TCC_NUM_CH 20
`define TCC_CH_SLEEP 5'h17
`define TCC_CH_MULTI 5'h00
`define TCC_TYPE_HI 31
`define TCC_TYPE_LO 27
`define TCC_TYPE_W 5
`define TCC_COMP_HI 26
`define TCC_COMP_LO 22
`define TCC_TYPE_UNASSIGNED 5'h00
`define TCC_TYPE_TC_LAST 5'h09
`define TCC_TYPE_RTD_FIRST 5'h0a
`define TCC_TYPE_THERM_LAST 5'h1b
`define TCC_TYPE_DIODE 5'h1c
`define TCC_TYPE_SENSE 5'h1d
`define TCC_TYPE_ADC 5'h1e
`define TCC_TYPE_RESERVED 5'h1f
`define TCC_VALID_BIT 24
`define TCC_CYCLE_MS 82
`define TCC_CYCLES_PLAIN 2'h2
`define TCC_CYCLES_COMP 2'h3
`define TCC_CLK_KHZ 20000
`define TCC_CMD_IDLE 8'h40
`define TCC_STATUS_DONE 2'h1
`endif

// *** hdl/tcc_pkg.sv ***
// types shared by the conversion command ends
package tcc_pkg;
    typedef enum logic [1:0] {tcc_idle, tcc_convert, tcc_sleep} tcc_mode_t;
    typedef enum logic [1:0] {tcc_h_idle, tcc_h_write, tcc_h_poll} tcc_hstate_t;
endpackage : tcc_pkg

// *** hdl/tcc_link_if.sv ***
// memory port between host and conversion device
`timescale 1ns/1ns
interface tcc_link_if;
    logic [9:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic rvalid;
    logic busy_n;
    modport dev (input addr, input wr, input rd, input wdata,
                 output rdata, output rvalid, output busy_n);
    modport host (output addr, output wr, output rd, output wdata,
                  input rdata, input rvalid, input busy_n);
endinterface : tcc_link_if

// *** hdl/tcc_cycle_timer.sv ***
// counts measurement cycles of one conversion
`timescale 1ns/1ns
`include "tcc_params.svh"
module tcc_cycle_timer
    import tcc_pkg::*;
#(
    parameter int CYCLE_CLKS = `TCC_CYCLE_MS * `TCC_CLK_KHZ
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic start,
    input wire logic [1:0] cycles,
    output logic done
);
    typedef struct packed {
        logic [31:0] cnt;
        logic [1:0] left;
        logic run;
        logic done;
    } tcc_tmr_t;
    tcc_tmr_t r, next_r;
    always_comb begin
        next_r = r;
        next_r.done = 1'b0;
        if (start) begin
            next_r.run = 1'b1;
            next_r.left = cycles;
            next_r.cnt = 32'h0;
        end else if (r.run) begin
            if (r.cnt == 32'(CYCLE_CLKS - 1)) begin
                next_r.cnt = 32'h0;
                next_r.left = r.left - 2'h1;
                if (r.left == 2'h1) begin
                    next_r.run = 1'b0;
                    next_r.done = 1'b1;
                end
            end else begin
                next_r.cnt = r.cnt + 32'h1;
            end
        end
    end
    always_ff @(posedge clk) begin
        if (reset) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end
    assign done = r.done;
endmodule : tcc_cycle_timer

// *** hdl/tcc_device.sv ***
// command and status end of the temperature measurement device
//
// What this block does
// (R1) Top five assignment bits pick sensor kind.
// (R2) Other assignment bits hold sensor settings.
// (R3) Host starts by writing start, channel byte.
// (R4) Channel zero runs multi-channel cycle.
// (R5) Channel field is binary number, 1..20.
// (R6) Host writes bit five as zero.
// (R7) Channel 10111 command enters sleep.
// (R8) Every other command byte is reserved.
// (R9) Cycle begins when start lands at zero.
// (R10) Completion pin low during conversion.
// (R11) Finish sets flags 01, pin high.
// (R12) Companion channel measured in same cycle.
// (R13) Memory locked while converting except status.
// (R14) Two or three 82 ms cycles each.
// (R15) Host sees end by edge or polling.
// (R16) Results are 32 bits, bit 24 valid.
// (R17) New start accepted once idle, results read or not.
// (R18) Busy: writes ignored, other reads invalid.
`timescale 1ns/1ns
`include "tcc_params.svh"
module tcc_device
    import tcc_pkg::*;
#(
    parameter int CYCLE_CLKS = `TCC_CYCLE_MS * `TCC_CLK_KHZ,
    parameter logic [23:0] RESULT_TEMP = 24'h000400
) (
    input wire logic clk,
    input wire logic reset,
    tcc_link_if.dev link,
    output logic sleeping,
    output logic [4:0] active_channel
);
    typedef struct packed {
        tcc_mode_t mode;
        logic [7:0] cmd;
        logic [4:0] chan;
        logic [4:0] scan;
        logic multi;
        logic [7:0] rdata;
        logic rvalid;
        logic busy_n;
        logic tstart;
        logic sleeping;
        logic [4:0] act;
    } tcc_dev_t;
    tcc_dev_t r, next_r;
    logic [31:0] assign_mem [`TCC_NUM_CH];
    logic [31:0] result_mem [`TCC_NUM_CH];
    logic tdone;
    logic [4:0] cur;
    logic cur_ok;
    logic [4:0] cur_idx;
    logic [4:0] ktype;
    logic [4:0] comp;
    logic need_comp;
    logic [1:0] ncycles;
    logic [`TCC_ADDR_W-1:0] aoff;
    logic [`TCC_ADDR_W-1:0] roff;
    logic [4:0] aidx;
    logic [4:0] ridx;
    logic in_res;
    logic in_assign;
    logic cmd_wr;
    logic [4:0] wchan;
    logic cmd_shape;
    logic cmd_ok_start;
    logic cmd_sleep;

    ////////////////////////////////////////////////////////////////////////
    tcc_cycle_timer #(.CYCLE_CLKS(CYCLE_CLKS)) u_timer (
        .clk(clk),
        .reset(reset),
        .start(r.tstart),
        .cycles(ncycles),
        .done(tdone)
    );

    ////////////////////////////////////////////////////////////////////////
    // a zero or out-of-range channel maps to entry 0 rather than reading past the array
    assign cur = r.multi ? r.scan : r.chan;
    assign cur_ok = (cur != 5'h0) && (cur <= 5'(`TCC_NUM_CH));
    assign cur_idx = cur_ok ? cur - 5'h1 : 5'h0;
    assign ktype = assign_mem[cur_idx][`TCC_TYPE_HI:`TCC_TYPE_LO]; // R1
    assign comp = assign_mem[cur_idx][`TCC_COMP_HI:`TCC_COMP_LO]; // R2
    // thermocouples, detectors and thermistors carry a companion channel
    assign need_comp = (ktype != `TCC_TYPE_UNASSIGNED) && (ktype <= `TCC_TYPE_THERM_LAST)
        && (comp != 5'h0); // R12
    // combinational on purpose: the timer samples it with its start pulse, the first cycle
    // in which cur already names the newly selected channel
    assign ncycles = need_comp ? `TCC_CYCLES_COMP : `TCC_CYCLES_PLAIN; // R14

    ////////////////////////////////////////////////////////////////////////
    assign aoff = link.addr - `TCC_ASSIGN_BASE;
    assign roff = link.addr - `TCC_RES_BASE;
    assign aidx = aoff[6:2];
    assign ridx = roff[6:2];
    assign in_res = (link.addr >= `TCC_RES_BASE) && (link.addr <= `TCC_RES_END);
    assign in_assign = (link.addr >= `TCC_ASSIGN_BASE) && (link.addr <= `TCC_ASSIGN_END);
    assign cmd_wr = link.wr && (link.addr == `TCC_CMD_ADDR);
    // flags 10 with the spare bit clear; the channel field then picks start or sleep
    assign wchan = link.wdata[`TCC_CHAN_HI:0];
    assign cmd_shape = link.wdata[`TCC_START_BIT] && !link.wdata[`TCC_DONE_BIT]
        && !link.wdata[`TCC_SPARE_BIT];
    assign cmd_ok_start = cmd_shape && (wchan <= 5'(`TCC_NUM_CH)); // R4 R5 R8
    assign cmd_sleep = cmd_shape && (wchan == `TCC_CH_SLEEP); // R7

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_r = r;
        next_r.tstart = 1'b0;
        next_r.rvalid = 1'b0;
        next_r.rdata = 8'h00;
        // reads answer one cycle later, except non-status reads while converting; unmapped addresses return zero
        if (link.rd) begin
            next_r.rvalid = 1'b1;
            if (link.addr == `TCC_CMD_ADDR) begin
                next_r.rdata = r.cmd;
            end else if (r.mode == tcc_convert) begin
                next_r.rvalid = 1'b0; // R13 R18
            end else if (in_res) begin
                next_r.rdata = 8'(result_mem[ridx] >> {~roff[1:0], 3'h0}); // R16
            end else if (in_assign) begin
                next_r.rdata = 8'(assign_mem[aidx] >> {~aoff[1:0], 3'h0});
            end
        end
        case (r.mode)
            tcc_idle, tcc_sleep: begin
                // any command write other than sleep wakes from sleep; only a valid start acts further
                if (cmd_wr) begin // R9 R17
                    if (cmd_sleep) begin
                        next_r.mode = tcc_sleep;
                    end else if (cmd_ok_start) begin
                        next_r.mode = tcc_convert;
                        next_r.cmd = link.wdata;
                        next_r.chan = wchan;
                        next_r.multi = wchan == `TCC_CH_MULTI; // R4
                        next_r.scan = 5'h1;
                        next_r.busy_n = 1'b0; // R10
                        next_r.tstart = 1'b1;
                    end else begin
                        next_r.mode = tcc_idle; // R8
                    end
                end
            end
            tcc_convert: begin
                // writes are dropped outright while busy
                if (r.tstart || tdone) begin // R18
                    if (!r.tstart && (!r.multi || r.scan == 5'(`TCC_NUM_CH))) begin
                        next_r.mode = tcc_idle;
                        next_r.cmd = {`TCC_STATUS_DONE, r.cmd[5:0]}; // R11
                        next_r.busy_n = 1'b1; // R11
                    end else begin
                        if (!r.tstart) begin
                            next_r.scan = r.scan + 5'h1;
                        end
                        next_r.tstart = r.tstart ? 1'b0 : 1'b1;
                    end
                end
            end
            default: next_r.mode = tcc_idle;
        endcase
        next_r.sleeping = next_r.mode == tcc_sleep;
        if (next_r.mode == tcc_convert) begin
            next_r.act = next_r.multi ? next_r.scan : next_r.chan;
        end else begin
            next_r.act = 5'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk) begin
        if (reset) begin
            r <= '0;
            r.cmd <= `TCC_CMD_IDLE;
            r.busy_n <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // memories: assignment words written bytewise when not converting, results on cycle end
    generate
        for (genvar i = 0; i < `TCC_NUM_CH; i++) begin : g_ch
            always_ff @(posedge clk) begin
                if (reset) begin
                    assign_mem[i] <= 32'h0;
                    result_mem[i] <= 32'h0;
                end else begin
                    if (link.wr && r.mode != tcc_convert && in_assign && aidx == 5'(i)) begin
                        assign_mem[i][{~aoff[1:0], 3'h0} +: 8] <= link.wdata; // R13
                    end
                    if (r.mode == tcc_convert && tdone && cur == 5'(i + 1)) begin
                        result_mem[i] <= (ktype == `TCC_TYPE_UNASSIGNED) ? 32'h0
                            : {7'h0, 1'b1, RESULT_TEMP}; // R16
                    end
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    assign link.rdata = r.rdata;
    assign link.rvalid = r.rvalid;
    assign link.busy_n = r.busy_n;
    assign sleeping = r.sleeping;
    assign active_channel = r.act;
endmodule : tcc_device

// *** hdl/tcc_host.sv ***
// host end: issues start, waits for completion edge or polls status
`timescale 1ns/1ns
`include "tcc_params.svh"
module tcc_host
    import tcc_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    tcc_link_if.host link,
    input wire logic go,
    input wire logic [4:0] go_channel,
    input wire logic use_poll,
    output logic busy,
    output logic finished
);
    typedef struct packed {
        tcc_hstate_t st;
        logic [9:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
        logic busy;
        logic finished;
        logic pin_s1;
        logic pin_s2;
        logic pin_prev;
    } tcc_host_st_t;
    tcc_host_st_t r, next_r;

    always_comb begin
        next_r = r;
        next_r.wr = 1'b0;
        next_r.rd = 1'b0;
        next_r.finished = 1'b0;
        next_r.pin_s1 = link.busy_n;
        next_r.pin_s2 = r.pin_s1;
        next_r.pin_prev = r.pin_s2;
        case (r.st)
            tcc_h_idle: begin
                if (go) begin
                    next_r.st = tcc_h_write;
                    next_r.wr = 1'b1;
                    next_r.addr = `TCC_CMD_ADDR;
                    next_r.wdata = {1'b1, 1'b0, 1'b0, go_channel}; // R3 R6
                    next_r.busy = 1'b1;
                end
            end
            tcc_h_write: begin
                next_r.st = tcc_h_poll;
            end
            tcc_h_poll: begin
                next_r.rd = use_poll && !r.rd;
                // edge seen on synchronised pin, or status reads done
                if ((!use_poll && r.pin_s2 && !r.pin_prev) || (use_poll && link.rvalid
                    && link.rdata[`TCC_START_BIT:`TCC_DONE_BIT] == `TCC_STATUS_DONE)) begin // R15
                    next_r.st = tcc_h_idle;
                    next_r.busy = 1'b0;
                    next_r.finished = 1'b1;
                    next_r.rd = 1'b0;
                end
            end
            default: next_r.st = tcc_h_idle;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            r <= '0;
            r.pin_s1 <= 1'b1;
            r.pin_s2 <= 1'b1;
            r.pin_prev <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    assign link.addr = r.addr;
    assign link.wr = r.wr;
    assign link.rd = r.rd;
    assign link.wdata = r.wdata;
    assign busy = r.busy;
    assign finished = r.finished;
endmodule : tcc_host

// *** dv/tcc_link_monitor.sv ***
// checker on the link between the host end and the device end
`timescale 1ns/1ns
module tcc_link_monitor (
    input wire logic clk,
    input wire logic reset,
    input wire logic [9:0] addr,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic rvalid,
    input wire logic busy_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    ////////////////////////////////////////
    property p_start;
        busy_n && wr && addr == 10'h000 && wdata[7:5] == 3'b100 && wdata[4:0] <= 5'h14
        |=> !busy_n;
    endproperty
    a_start: assert property (p_start) else $error("start not followed by busy");
    property p_min_low;
        $fell(busy_n) |-> !busy_n [*8];
    endproperty
    a_min_low: assert property (p_min_low) else $error("conversion too short");
    // multi-channel scans all twenty inputs, so the bound is generous
    property p_max_low;
        $fell(busy_n) |-> ##[1:600] busy_n;
    endproperty
    a_max_low: assert property (p_max_low) else $error("conversion never ends");
    property p_rvalid_cause;
        rvalid |-> $past(rd);
    endproperty
    a_rvalid_cause: assert property (p_rvalid_cause) else $error("answer without read");
    property p_status_answer;
        rd && addr == 10'h000 |=> rvalid;
    endproperty
    a_status_answer: assert property (p_status_answer) else $error("status unread");
    property p_lock;
        !busy_n && rd && addr != 10'h000 |=> !rvalid;
    endproperty
    a_lock: assert property (p_lock) else $error("memory read while busy");
    property p_busy_status;
        rd && addr == 10'h000 && !busy_n |=> rdata[7:6] == 2'b10;
    endproperty
    a_busy_status: assert property (p_busy_status) else $error("flags not 10 busy");
    property p_idle_status;
        rd && addr == 10'h000 && busy_n |=> rdata[7:6] == 2'b01;
    endproperty
    a_idle_status: assert property (p_idle_status) else $error("flags not 01 idle");
    c_start: cover property ($fell(busy_n));
    c_done: cover property ($rose(busy_n));
    c_poll: cover property (rd && addr == 10'h000 && !busy_n);
endmodule : tcc_link_monitor

// *** dv/testbench.sv ***
// self-checking bench for the host and device ends of the conversion link
`timescale 1ns/1ns
module testbench;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic go = 1'b0;
    logic [4:0] go_channel = 5'h05;
    logic use_poll = 1'b0;
    logic busy;
    logic finished;
    logic sleeping;
    logic [4:0] active_channel;
    logic [7:0] rd_data;
    logic rd_ok;
    logic [7:0] bad [5] = '{8'hc3, 8'ha3, 8'h95, 8'h9f, 8'h03};
    int mismatches = 0;
    int tests_run = 0;
    int n;
    tcc_link_if link_a();
    tcc_link_if link_b();
    always #25 clk = ~clk;
    tcc_host tcc_host_i (.clk(clk), .reset(reset), .link(link_a), .go(go),
        .go_channel(go_channel), .use_poll(use_poll), .busy(busy), .finished(finished));
    tcc_device #(.CYCLE_CLKS(4)) tcc_device_i (.clk(clk), .reset(reset), .link(link_a),
        .sleeping(), .active_channel());
    // second device is driven by the bench so it can be misused on purpose
    tcc_device #(.CYCLE_CLKS(4)) tcc_device_b_i (.clk(clk), .reset(reset), .link(link_b),
        .sleeping(sleeping), .active_channel(active_channel));
    tcc_link_monitor tcc_link_monitor_i (.clk(clk), .reset(reset), .addr(link_a.addr),
        .wr(link_a.wr), .rd(link_a.rd), .wdata(link_a.wdata), .rdata(link_a.rdata),
        .rvalid(link_a.rvalid), .busy_n(link_a.busy_n));
    ////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %0t ns seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic bus_wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge clk);
        link_b.addr <= a;
        link_b.wdata <= d;
        link_b.wr <= 1'b1;
        @(posedge clk);
        link_b.wr <= 1'b0;
        #1;
    endtask : bus_wr
    task automatic rd_chk(input logic [9:0] a, input logic ok, input logic [7:0] exp);
        @(posedge clk);
        link_b.addr <= a;
        link_b.rd <= 1'b1;
        @(posedge clk);
        link_b.rd <= 1'b0;
        #1;
        rd_ok = link_b.rvalid;
        rd_data = link_b.rdata;
        check({7'h00, rd_ok}, {7'h00, ok});
        if (ok) check(rd_data, exp);
    endtask : rd_chk
    task automatic wait_idle(input int lo);
        n = 0;
        while (link_b.busy_n !== 1'b1 && n < 2000) begin
            @(posedge clk);
            #1;
            n++;
        end
        check(8'(n >= lo && n < 2000), 8'h01);
    endtask : wait_idle
    task automatic convert(input logic [7:0] cmd, input int lo);
        bus_wr(10'h000, cmd);
        check({7'h00, link_b.busy_n}, 8'h00);
        check({3'h0, active_channel}, {3'h0, cmd[4:0]});
        wait_idle(lo);
    endtask : convert
    task automatic report_and_stop;
        if (mismatches == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : report_and_stop
    ////////////////////////////////////////
    initial begin
        #(50 * 20000);
        mismatches++;
        report_and_stop();
    end
    initial begin
        link_b.addr = 10'h000;
        link_b.wr = 1'b0;
        link_b.rd = 1'b0;
        link_b.wdata = 8'h00;
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        // host end: edge wait for one channel, then polling over all channels
        for (int p = 0; p < 2; p++) begin
            @(posedge clk);
            use_poll <= p[0];
            go_channel <= p[0] ? 5'h00 : 5'h05;
            go <= 1'b1;
            @(posedge clk);
            go <= 1'b0;
            #1;
            check({7'h00, busy}, 8'h01);
            n = 0;
            while (finished !== 1'b1 && n < 2000) begin
                @(posedge clk);
                #1;
                n++;
            end
            check({7'h00, finished}, 8'h01);
            check({7'h00, link_a.busy_n}, 8'h01);
            check({7'h00, busy}, 8'h00);
        end
        rd_chk(10'h000, 1'b1, 8'h40);
        bus_wr(10'h208, 8'h08);
        rd_chk(10'h208, 1'b1, 8'h08);
        rd_chk(10'h100, 1'b1, 8'h00);
        convert(8'h83, 8);
        rd_chk(10'h000, 1'b1, 8'h43);
        rd_chk(10'h018, 1'b1, 8'h01);
        rd_chk(10'h01a, 1'b1, 8'h04);
        bus_wr(10'h209, 8'h40);
        convert(8'h83, 12);
        foreach (bad[i]) begin
            bus_wr(10'h000, bad[i]);
            check({7'h00, link_b.busy_n}, 8'h01);
        end
        rd_chk(10'h000, 1'b1, 8'h43);
        bus_wr(10'h000, 8'h97);
        check({7'h00, sleeping}, 8'h01);
        check({7'h00, link_b.busy_n}, 8'h01);
        convert(8'h83, 12);
        check({7'h00, sleeping}, 8'h00);
        bus_wr(10'h000, 8'h80);
        check({7'h00, link_b.busy_n}, 8'h00);
        rd_chk(10'h208, 1'b0, 8'h00);
        bus_wr(10'h208, 8'hf8);
        rd_chk(10'h000, 1'b1, 8'h80);
        wait_idle(1);
        rd_chk(10'h000, 1'b1, 8'h40);
        rd_chk(10'h208, 1'b1, 8'h08);
        report_and_stop();
    end
endmodule : testbench
